//--- asp_uart_top.sv
// Design decisions made here: the AXI4-Lite register port and the register addresses.
`include "asp_consts.svh"

// Function
// - full duplex port, 8-bit and 9-bit framing
// - received byte buffered apart from shifter
// - data buffer writes go to transmitter
// - data buffer reads return receive buffer
// - interrupt on done flags when enabled
// - done flags cleared only by software
// - tx bit clock from low count overflow
// - rx bit clock from hidden twin counter
// - both overflows halved for baud clocks
// - twin runs with timer, same reload byte
// - start edge forces twin counter reload
// - six selectable timer count sources
// - baud equals clock/(256-reload)/2
// - external oscillator may clock timer only
// - 8-bit frame: start, 8 lsb-first, stop
// - 9-bit frame adds ninth bit, stored
// - load only if flag clear, check passes
// - one select bit sets framing both ways
module asp_uart_top (
    input  wire logic        i_clk_sys,
    input  wire logic        i_rst,
    // axi4-lite slave
    input  wire logic [7:0]  i_awaddr,
    input  wire logic        i_awvalid,
    output logic             o_awready,
    input  wire logic [31:0] i_wdata,
    input  wire logic [3:0]  i_wstrb,
    input  wire logic        i_wvalid,
    output logic             o_wready,
    output logic [1:0]       o_bresp,
    output logic             o_bvalid,
    input  wire logic        i_bready,
    input  wire logic [7:0]  i_araddr,
    input  wire logic        i_arvalid,
    output logic             o_arready,
    output logic [31:0]      o_rdata,
    output logic [1:0]       o_rresp,
    output logic             o_rvalid,
    input  wire logic        i_rready,
    // serial line and timer pins
    input  wire logic        i_rxd,
    output logic             o_txd,
    input  wire logic        i_ext_osc,
    input  wire logic        i_timer_one_ext_input,
    output logic             o_irq
);
    import asp_pkg::*;

    // serial_control_reg fields
    logic       frame_length_select;
    logic       multiproc_check_enable;
    logic       rx_enable_bit;
    logic       ninth_tx_bit;
    logic       ninth_rx_bit;
    logic       tx_done_flag;
    logic       rx_done_flag;
    // timer control and reload
    logic       tmr_run;
    logic [2:0] clk_sel;
    logic       irq_en;
    logic [7:0] timer_one_reload_byte;
    logic [7:0] rx_buf;          // serial_data_buffer read side
    logic [7:0] timer_one_low_count;

    // bus decode
    logic       wr_fire;
    logic       wr_ctrl;
    logic       wr_data;
    logic       wr_tmr;
    logic       wr_reload;
    logic       wr_low;
    logic       rd_fire;
    logic       wr_hit;
    logic       rd_hit;
    logic [7:0] next_rdata;

    assign wr_fire   = i_awvalid & o_awready & i_wvalid & o_wready;
    assign wr_ctrl   = wr_fire & i_wstrb[0] & (i_awaddr == `ASP_OFF_CTRL);
    assign wr_data   = wr_fire & i_wstrb[0] & (i_awaddr == `ASP_OFF_DATA);
    assign wr_tmr    = wr_fire & i_wstrb[0] & (i_awaddr == `ASP_OFF_TMR);
    assign wr_reload = wr_fire & i_wstrb[0] & (i_awaddr == `ASP_OFF_RELOAD);
    assign wr_low    = wr_fire & i_wstrb[0] & (i_awaddr == `ASP_OFF_LOW);
    assign rd_fire   = i_arvalid & o_arready;
    assign wr_hit = (i_awaddr == `ASP_OFF_CTRL) | (i_awaddr == `ASP_OFF_DATA)
                  | (i_awaddr == `ASP_OFF_TMR) | (i_awaddr == `ASP_OFF_RELOAD)
                  | (i_awaddr == `ASP_OFF_LOW);
    assign rd_hit = (i_araddr == `ASP_OFF_CTRL) | (i_araddr == `ASP_OFF_DATA)
                  | (i_araddr == `ASP_OFF_TMR) | (i_araddr == `ASP_OFF_RELOAD)
                  | (i_araddr == `ASP_OFF_LOW);

    // write channel: take address and data together, answer one cycle later
    always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            o_awready <= 1'b0;
            o_wready  <= 1'b0;
            o_bvalid  <= 1'b0;
            o_bresp   <= `ASP_RESP_OK;
        end else begin
            o_awready <= 1'b0;
            o_wready  <= 1'b0;
            if (wr_fire) begin
                o_bvalid <= 1'b1;
                o_bresp  <= wr_hit ? `ASP_RESP_OK : `ASP_RESP_ERR;
            end else if (o_bvalid && i_bready) begin
                o_bvalid <= 1'b0;
            end else if (!o_bvalid && i_awvalid && i_wvalid && !o_awready) begin
                o_awready <= 1'b1;
                o_wready  <= 1'b1;
            end
        end
    end

    // read mux, narrow registers in the low byte
    always_comb begin
        next_rdata = 8'h00;
        unique case (i_araddr)
            `ASP_OFF_CTRL: next_rdata = {frame_length_select, 1'b1,
                multiproc_check_enable, rx_enable_bit, ninth_tx_bit,
                ninth_rx_bit, tx_done_flag, rx_done_flag};
            `ASP_OFF_DATA:   next_rdata = rx_buf;
            `ASP_OFF_TMR:    next_rdata = {3'h0, irq_en, clk_sel, tmr_run};
            `ASP_OFF_RELOAD: next_rdata = timer_one_reload_byte;
            `ASP_OFF_LOW:    next_rdata = timer_one_low_count;
            default:         next_rdata = 8'h00;
        endcase
    end

    // read channel
    always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            o_arready <= 1'b0;
            o_rvalid  <= 1'b0;
            o_rdata   <= 32'h0000_0000;
            o_rresp   <= `ASP_RESP_OK;
        end else begin
            o_arready <= 1'b0;
            if (rd_fire) begin
                o_rvalid <= 1'b1;
                o_rdata  <= {24'h00_0000, next_rdata};
                o_rresp  <= rd_hit ? `ASP_RESP_OK : `ASP_RESP_ERR;
            end else if (o_rvalid && i_rready) begin
                o_rvalid <= 1'b0;
            end else if (!o_rvalid && i_arvalid && !o_arready) begin
                o_arready <= 1'b1;
            end
        end
    end

    // timer clock sources; external pins are sampled, so they must
    // stay below half the system clock
    logic       osc_s1, osc_s2, osc_d;
    logic       pin_s1, pin_s2, pin_d;
    logic [1:0] pre4, pre12, pre48;
    logic [2:0] ext8;
    logic       tick4, tick12, tick48, osc_rise, pin_fall, tick;

    assign tick4    = (pre4 == `ASP_PRE4_END);
    assign tick12   = tick4 & (pre12 == `ASP_PRE12_END);
    assign tick48   = tick12 & (pre48 == `ASP_PRE48_END);
    assign osc_rise = osc_s2 & ~osc_d;
    assign pin_fall = ~pin_s2 & pin_d;

    // synchronisers and prescalers
    always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            {osc_s1, osc_s2, osc_d} <= 3'h0;
            {pin_s1, pin_s2, pin_d} <= 3'h7;
            pre4  <= 2'h0;
            pre12 <= 2'h0;
            pre48 <= 2'h0;
            ext8  <= 3'h0;
        end else begin
            osc_s1 <= i_ext_osc;
            osc_s2 <= osc_s1;
            osc_d  <= osc_s2;
            pin_s1 <= i_timer_one_ext_input;
            pin_s2 <= pin_s1;
            pin_d  <= pin_s2;
            pre4   <= pre4 + 2'h1;
            if (tick4) begin
                pre12 <= (pre12 == `ASP_PRE12_END) ? 2'h0 : pre12 + 2'h1;
            end
            if (tick12) begin
                pre48 <= pre48 + 2'h1;
            end
            if (osc_rise) begin
                ext8 <= ext8 + 3'h1;
            end
        end
    end

    // source select; system clock itself never switches source
    always_comb begin
        unique case (asp_clk_sel_t'(clk_sel))
            CLK_SYS:   tick = 1'b1;
            CLK_DIV4:  tick = tick4;
            CLK_DIV12: tick = tick12;
            CLK_DIV48: tick = tick48;
            CLK_EXT8:  tick = osc_rise & (ext8 == `ASP_EXT8_END);
            CLK_PIN:   tick = pin_fall;
            default:   tick = 1'b0;
        endcase
    end

    // receive line synchroniser and start detect
    logic          rx_s1, rx_s2, rx_d;
    asp_rx_state_t rx_state;
    logic [3:0]    rx_cnt;
    logic [7:0]    rx_sh;
    logic          rx_ninth;
    logic          rx_start, rx_baud, tx_baud;
    logic          rx_final, rx_chk, rx_set, tx_set;
    logic [3:0]    tx_cnt;
    logic [10:0]   tx_sh;

    assign rx_start = (rx_state == RX_IDLE) & rx_enable_bit & rx_d & ~rx_s2;
    assign rx_final = (rx_state == RX_BUSY) & rx_baud & (rx_cnt ==
        (frame_length_select ? `ASP_RX_LAST9 : `ASP_RX_LAST8));
    assign rx_chk = frame_length_select ? rx_ninth : rx_s2;
    assign rx_set = rx_final & ~rx_done_flag & (~multiproc_check_enable | rx_chk);
    assign tx_set = tx_baud & (tx_cnt == `ASP_TX_STOP);

    asp_baud_gen u_baud (
        .i_clk_sys   (i_clk_sys),
        .i_rst       (i_rst),
        .i_tick      (tick),
        .i_run       (tmr_run),
        .i_reload    (timer_one_reload_byte),
        .i_wr_low    (wr_low),
        .i_low_wdata (i_wdata[7:0]),
        .i_rx_start  (rx_start),
        .o_low       (timer_one_low_count),
        .o_tx_baud   (tx_baud),
        .o_rx_baud   (rx_baud)
    );

    // receiver: sample start, data lsb first, optional ninth, stop
    always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            {rx_s1, rx_s2, rx_d} <= 3'h7;
            rx_state <= RX_IDLE;
            rx_cnt   <= 4'h0;
            rx_sh    <= 8'h00;
            rx_ninth <= 1'b0;
        end else begin
            rx_s1 <= i_rxd;
            rx_s2 <= rx_s1;
            rx_d  <= rx_s2;
            if (rx_start) begin
                rx_state <= RX_BUSY;
                rx_cnt   <= 4'h0;
            end else if (rx_state == RX_BUSY && rx_baud) begin
                if (rx_cnt == 4'h0 && rx_s2) begin
                    rx_state <= RX_IDLE;  // glitch, not a start bit
                end else if (rx_final) begin
                    rx_state <= RX_IDLE;
                end else begin
                    if (rx_cnt != 4'h0 && rx_cnt <= `ASP_RX_DATA_END) begin
                        rx_sh <= {rx_s2, rx_sh[7:1]};
                    end
                    if (rx_cnt == `ASP_RX_NINTH) begin
                        rx_ninth <= rx_s2;
                    end
                    rx_cnt <= rx_cnt + 4'h1;
                end
            end
        end
    end

    // receive buffer frees the shifter for the next frame
    always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            rx_buf <= `ASP_BYTE_RST;
        end else if (rx_set) begin
            rx_buf <= rx_sh;
        end
    end

    // transmitter: a write always (re)loads the frame
    always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            tx_cnt <= 4'h0;
            tx_sh  <= 11'h7ff;
            o_txd  <= 1'b1;
        end else if (wr_data) begin
            tx_sh  <= {1'b1, frame_length_select ? ninth_tx_bit : 1'b1,
                       i_wdata[7:0], 1'b0};
            tx_cnt <= frame_length_select ? `ASP_TX_LOAD9 : `ASP_TX_LOAD8;
        end else if (tx_baud && tx_cnt != 4'h0) begin
            if (tx_cnt != `ASP_TX_END) begin
                o_txd <= tx_sh[0];
                tx_sh <= {1'b1, tx_sh[10:1]};
            end
            tx_cnt <= tx_cnt - 4'h1;
        end
    end

    // control register; hardware set beats a software clear
    always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            {frame_length_select, multiproc_check_enable, rx_enable_bit,
             ninth_tx_bit, ninth_rx_bit, tx_done_flag, rx_done_flag} <= 7'h00;
        end else begin
            if (wr_ctrl) begin
                frame_length_select    <= i_wdata[`ASP_B_MODE];
                multiproc_check_enable <= i_wdata[`ASP_B_MCE];
                rx_enable_bit          <= i_wdata[`ASP_B_REN];
                ninth_tx_bit           <= i_wdata[`ASP_B_TB8];
            end
            ninth_rx_bit <= rx_set ? rx_chk
                          : (wr_ctrl ? i_wdata[`ASP_B_RB8] : ninth_rx_bit);
            tx_done_flag <= tx_set | (wr_ctrl ? i_wdata[`ASP_B_TI] : tx_done_flag);
            rx_done_flag <= rx_set | (wr_ctrl ? i_wdata[`ASP_B_RI] : rx_done_flag);
        end
    end

    // timer control and reload byte
    always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            tmr_run <= 1'b0;
            clk_sel <= `ASP_SEL_RST;
            irq_en  <= 1'b0;
            timer_one_reload_byte <= `ASP_BYTE_RST;
        end else begin
            if (wr_tmr) begin
                tmr_run <= i_wdata[`ASP_B_RUN];
                clk_sel <= i_wdata[`ASP_B_SEL_HI:`ASP_B_SEL_LO];
                irq_en  <= i_wdata[`ASP_B_IE];
            end
            if (wr_reload) begin
                timer_one_reload_byte <= i_wdata[7:0];
            end
        end
    end

    // interrupt request follows the sticky flags
    always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            o_irq <= 1'b0;
        end else begin
            o_irq <= irq_en & (tx_done_flag | rx_done_flag);
        end
    end

    irq_rise_a: assert property (
        @(posedge i_clk_sys) disable iff (i_rst)
        (irq_en && ($rose(tx_done_flag) || $rose(rx_done_flag))) |=> o_irq)
        else $error("irq missing after done flag");
    ti_sticky_a: assert property (
        @(posedge i_clk_sys) disable iff (i_rst)
        (tx_done_flag && !wr_ctrl) |=> tx_done_flag)
        else $error("tx done cleared by hardware");
    ri_sticky_a: assert property (
        @(posedge i_clk_sys) disable iff (i_rst)
        (rx_done_flag && !wr_ctrl) |=> rx_done_flag)
        else $error("rx done cleared by hardware");
    buf_hold_a: assert property (
        @(posedge i_clk_sys) disable iff (i_rst)
        rx_done_flag |=> $stable(rx_buf))
        else $error("receive buffer overwritten while full");
    data_read_a: assert property (
        @(posedge i_clk_sys) disable iff (i_rst)
        (rd_fire && i_araddr == `ASP_OFF_DATA) |=> o_rdata[7:0] == $past(rx_buf))
        else $error("data read not from receive buffer");
    tx_load_a: assert property (
        @(posedge i_clk_sys) disable iff (i_rst)
        wr_data |=> tx_cnt == (frame_length_select ? `ASP_TX_LOAD9 : `ASP_TX_LOAD8))
        else $error("data write did not start frame");
    stop_bit_a: assert property (
        @(posedge i_clk_sys) disable iff (i_rst)
        $rose(tx_done_flag) && !$past(wr_ctrl) |-> o_txd)
        else $error("tx done not at stop bit");
endmodule

//--- asp_consts.svh
`ifndef ASP_CONSTS_SVH
`define ASP_CONSTS_SVH

// register byte offsets
`define ASP_OFF_CTRL     8'h00
`define ASP_OFF_DATA     8'h04
`define ASP_OFF_TMR      8'h08
`define ASP_OFF_RELOAD   8'h0c
`define ASP_OFF_LOW      8'h10

// serial_control_reg field positions
`define ASP_B_MODE       7
`define ASP_B_ONE        6
`define ASP_B_MCE        5
`define ASP_B_REN        4
`define ASP_B_TB8        3
`define ASP_B_RB8        2
`define ASP_B_TI         1
`define ASP_B_RI         0

// timer control field positions
`define ASP_B_RUN        0
`define ASP_B_SEL_LO     1
`define ASP_B_SEL_HI     3
`define ASP_B_IE         4

// reset values
`define ASP_CTRL_RST     8'h40
`define ASP_BYTE_RST     8'h00
`define ASP_SEL_RST      3'h0

// bus responses
`define ASP_RESP_OK      2'h0
`define ASP_RESP_ERR     2'h2

// prescaler terminal counts (/4, /12 as 3 x /4, /48 as 4 x /12, ext /8)
`define ASP_PRE4_END     2'h3
`define ASP_PRE12_END    2'h2
`define ASP_PRE48_END    2'h3
`define ASP_EXT8_END     3'h7

// timer overflow point
`define ASP_CNT_MAX      8'hff

// transmit bit counter: load value per mode, stop bit slot, last slot
`define ASP_TX_LOAD8     4'hb
`define ASP_TX_LOAD9     4'hc
`define ASP_TX_STOP      4'h2
`define ASP_TX_END       4'h1

// receive sample counter: last data sample, ninth slot, final sample per mode
`define ASP_RX_DATA_END  4'h8
`define ASP_RX_NINTH     4'h9
`define ASP_RX_LAST8     4'h9
`define ASP_RX_LAST9     4'ha

`endif

//--- asp_pkg.sv
package asp_pkg;
    // timer one count clock sources
    typedef enum logic [2:0] {
        CLK_SYS,
        CLK_DIV4,
        CLK_DIV12,
        CLK_DIV48,
        CLK_EXT8,
        CLK_PIN
    } asp_clk_sel_t;

    // receiver states
    typedef enum logic {
        RX_IDLE,
        RX_BUSY
    } asp_rx_state_t;
endpackage

//--- asp_baud_gen.sv
`include "asp_consts.svh"

// timer one low count (tx) and its hidden receive twin, each halved
module asp_baud_gen (
    input  wire logic       i_clk_sys,
    input  wire logic       i_rst,
    input  wire logic       i_tick,
    input  wire logic       i_run,
    input  wire logic [7:0] i_reload,
    input  wire logic       i_wr_low,
    input  wire logic [7:0] i_low_wdata,
    input  wire logic       i_rx_start,
    output logic      [7:0] o_low,
    output logic            o_tx_baud,
    output logic            o_rx_baud
);
    import asp_pkg::*;

    logic [7:0] rx_cnt;     // receive twin, no bus access
    logic       tx_half;    // divide-by-two phases
    logic       rx_half;
    logic       step;       // one count step
    logic       tx_ovf;
    logic       rx_ovf;
    logic [1:0] ovf_gap;    // tx overflows since the last tx baud pulse

    assign step   = i_tick & i_run;
    assign tx_ovf = step & (o_low == `ASP_CNT_MAX);
    assign rx_ovf = step & (rx_cnt == `ASP_CNT_MAX) & ~i_rx_start;
    assign o_tx_baud = tx_ovf & tx_half;
    // first twin overflow after a start lands mid start bit
    assign o_rx_baud = rx_ovf & ~rx_half;

    // low count: software may write it, auto-reloads on overflow
    always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            o_low <= `ASP_BYTE_RST;
        end else if (i_wr_low) begin
            o_low <= i_low_wdata;
        end else if (step) begin
            o_low <= tx_ovf ? i_reload : o_low + 8'h01;
        end
    end

    // twin counter: same reload, forced reload on start
    always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            rx_cnt <= `ASP_BYTE_RST;
        end else if (i_rx_start) begin
            rx_cnt <= i_reload;
        end else if (step) begin
            rx_cnt <= rx_ovf ? i_reload : rx_cnt + 8'h01;
        end
    end

    // overflow count between tx baud pulses, saturates so a broken
    // divider cannot wrap back to a passing value
    always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            ovf_gap <= 2'h0;
        end else if (o_tx_baud) begin
            ovf_gap <= 2'h0;
        end else if (tx_ovf && ovf_gap != 2'h3) begin
            ovf_gap <= ovf_gap + 2'h1;
        end
    end

    // divide-by-two stages
    always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            tx_half <= 1'b0;
            rx_half <= 1'b0;
        end else begin
            if (tx_ovf) begin
                tx_half <= ~tx_half;
            end
            if (i_rx_start) begin
                rx_half <= 1'b0;
            end else if (rx_ovf) begin
                rx_half <= ~rx_half;
            end
        end
    end

    start_reload_a: assert property (
        @(posedge i_clk_sys) disable iff (i_rst)
        i_rx_start |=> rx_cnt == $past(i_reload))
        else $error("twin counter not reloaded on start");

    twin_hold_a: assert property (
        @(posedge i_clk_sys) disable iff (i_rst)
        (!i_run && !i_rx_start) |=> $stable(rx_cnt))
        else $error("twin counter moved while timer stopped");

    baud_div_a: assert property (
        @(posedge i_clk_sys) disable iff (i_rst)
        o_tx_baud |-> ovf_gap == 2'h1)
        else $error("tx baud not halved");
endmodule

//--- asp_peer.sv
// remote serial peer: sends frames on rxd, captures frames from txd
module asp_peer (
    input  wire logic i_clk_sys,
    input  wire logic i_txd,
    output logic      o_rxd
);
    timeunit 1ns;
    timeprecision 1ns;
    int          bit_cyc = 32; // system cycles per bit, set by bench
    bit          nine    = 0;  // 9-bit framing
    logic [9:0]  got[$];       // captured {stop, ninth, data}
    initial o_rxd = 1'b1;      // line idles high
    // one frame lsb first; stop always high
    task automatic send(input logic [7:0] d, input logic b9);
        logic [10:0] f;
        f = {1'b1, nine ? b9 : 1'b1, d, 1'b0};
        for (int i = 0; i < (nine ? 11 : 10); i++) begin
            o_rxd <= f[i];
            repeat (bit_cyc) @(posedge i_clk_sys);
        end
    endtask
    // mid-bit sampling from the falling start edge
    always begin
        logic [9:0] v;
        @(negedge i_txd);
        repeat (bit_cyc / 2) @(posedge i_clk_sys);
        if (i_txd == 1'b0) begin
            v = 10'h0;
            for (int i = 0; i < (nine ? 10 : 9); i++) begin
                repeat (bit_cyc) @(posedge i_clk_sys);
                v[(!nine && i == 8) ? 9 : i] = i_txd;
            end
            got.push_back(v);
        end
    end
endmodule

//--- testbench.sv
`include "asp_consts.svh"

module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    logic        i_clk_sys = 1'b0;
    logic        i_rst     = 1'b1;
    logic [7:0]  awaddr    = 8'h00;
    logic [7:0]  araddr    = 8'h00;
    logic [31:0] wdata     = 32'h0;
    logic        awvalid   = 1'b0;
    logic        wvalid    = 1'b0;
    logic        bready    = 1'b0;
    logic        arvalid   = 1'b0;
    logic        rready    = 1'b0;
    logic [1:0]  div       = 2'h0;  // slow clock divider
    logic        ext_osc   = 1'b0;  // 5 MHz osc, also count pin
    logic        awready, wready, bvalid, arready, rvalid, txd, rxd, irq;
    logic [1:0]  bresp, rresp;
    logic [31:0] rdata;
    int          n_errors = 0;
    int          checks_done = 0;
    logic [15:0] lfsr = 16'h3c8f;  // seed 15503
    // receiver model state
    logic [7:0]  m_ctrl = 8'h00, m_buf = 8'h00;
    logic        m_nine = 0, m_mce = 0, m_rb8 = 0, m_flag = 0;
    // per clock source: reload and resulting bit length
    int          bc[6] = '{32, 32, 24, 96, 64, 16};
    logic [7:0]  rl[6] = '{8'hf0, 8'hfc, 8'hff, 8'hff, 8'hff, 8'hfe};
    logic [7:0]  cv[8] = '{8'h10, 8'h10, 8'h10, 8'h90, 8'hb0, 8'hb0, 8'h30, 8'h30};

    always #25 i_clk_sys = ~i_clk_sys;
    // slow external source, well under half the system rate
    always @(posedge i_clk_sys) begin
        div     <= div + 2'h1;
        ext_osc <= div[1];
    end

    asp_uart_top u_dut (
        .i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_awaddr(awaddr), .i_awvalid(awvalid),
        .o_awready(awready), .i_wdata(wdata), .i_wstrb(4'hf), .i_wvalid(wvalid),
        .o_wready(wready), .o_bresp(bresp), .o_bvalid(bvalid), .i_bready(bready),
        .i_araddr(araddr), .i_arvalid(arvalid), .o_arready(arready), .o_rdata(rdata),
        .o_rresp(rresp), .o_rvalid(rvalid), .i_rready(rready), .i_rxd(rxd), .o_txd(txd),
        .i_ext_osc(ext_osc), .i_timer_one_ext_input(ext_osc), .o_irq(irq)
    );
    asp_peer peer (.i_clk_sys(i_clk_sys), .i_txd(txd), .o_rxd(rxd));

    function automatic logic [15:0] lfsr_next(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            n_errors++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic wrap_up;
        $display("checks %0d errors %0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask

    // axi write: leading edge keeps strobes from toggling twice in one step
    task automatic wr(input logic [7:0] a, input logic [7:0] d, output logic [1:0] r);
        @(posedge i_clk_sys);
        awaddr  <= a;
        wdata   <= {24'h0, d};
        awvalid <= 1'b1;
        wvalid  <= 1'b1;
        bready  <= 1'b1;
        do @(posedge i_clk_sys); while (!(awready && wready));
        awvalid <= 1'b0;
        wvalid  <= 1'b0;
        do @(posedge i_clk_sys); while (!bvalid);
        r = bresp;
        bready  <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        @(posedge i_clk_sys);
        araddr  <= a;
        arvalid <= 1'b1;
        rready  <= 1'b1;
        do @(posedge i_clk_sys); while (!arready);
        arvalid <= 1'b0;
        do @(posedge i_clk_sys); while (!rvalid);
        d = rdata;
        r = rresp;
        rready  <= 1'b0;
    endtask

    // control write, mirrored into the model
    task automatic set_ctrl(input logic [7:0] c);
        logic [1:0] r;
        wr(`ASP_OFF_CTRL, c, r);
        m_ctrl    = c;
        m_nine    = c[7];
        m_mce     = c[5];
        m_rb8     = c[2];
        m_flag    = c[0];
        peer.nine = c[7];
    endtask

    task automatic tx_one(input logic [7:0] d);
        logic [31:0] v;
        logic [1:0]  r;
        wr(`ASP_OFF_DATA, d, r);
        rd(`ASP_OFF_DATA, v, r);
        check("data readback", v, 32'(m_buf));
        do rd(`ASP_OFF_CTRL, v, r); while (v[1] !== 1'b1);
        repeat (4) @(posedge i_clk_sys);
        check("irq set", 32'(irq), 32'h1);
        rd(`ASP_OFF_CTRL, v, r);
        check("tx flag kept", 32'(v[1]), 32'h1);
        repeat (peer.bit_cyc * 2) @(posedge i_clk_sys);
        check("tx frame", 32'(peer.got.pop_front()), {23'h1, m_ctrl[3] & m_nine, d});
        wr(`ASP_OFF_CTRL, m_ctrl, r);
        repeat (3) @(posedge i_clk_sys);
        check("irq clear", 32'(irq), 32'h0);
    endtask

    // receive one frame, peeking at the buffer while it shifts
    task automatic rx_one(input logic [7:0] d, input logic b9);
        logic [31:0] v;
        logic [1:0]  r;
        fork
            peer.send(d, b9);
            begin
                repeat (peer.bit_cyc * 5) @(posedge i_clk_sys);
                rd(`ASP_OFF_DATA, v, r);
                check("rx hold", v, 32'(m_buf));
            end
        join
        if (!m_flag && (!m_mce || !m_nine || b9)) begin
            m_buf  = d;
            m_rb8  = m_nine ? b9 : 1'b1;
            m_flag = 1'b1;
        end
        repeat (peer.bit_cyc) @(posedge i_clk_sys);
        rd(`ASP_OFF_CTRL, v, r);
        check("rx flags", 32'(v[2:0]), {29'h0, m_rb8, 1'b0, m_flag});
        rd(`ASP_OFF_DATA, v, r);
        check("rx data", v, 32'(m_buf));
    endtask

    initial begin
        logic [31:0] v;
        logic [1:0]  r;
        repeat (20) @(posedge i_clk_sys);
        i_rst <= 1'b0;
        rd(`ASP_OFF_CTRL, v, r);
        check("ctrl reset", v, 32'h40);
        rd(`ASP_OFF_DATA, v, r);
        check("data reset", v, 32'h0);
        rd(8'h3c, v, r);
        check("unmapped resp", 32'(r), 32'(`ASP_RESP_ERR));
        wr(8'h3c, 8'h55, r);
        check("unmapped wr resp", 32'(r), 32'(`ASP_RESP_ERR));
        for (int i = 0; i < 6; i++) begin
            wr(`ASP_OFF_RELOAD, rl[i], r);
            wr(`ASP_OFF_TMR, {4'b0001, i[2:0], 1'b1}, r);
            peer.bit_cyc = bc[i];
            set_ctrl(i[0] ? 8'h88 : 8'h08);
            lfsr = lfsr_next(lfsr);
            tx_one(lfsr[7:0]);
        end
        wr(`ASP_OFF_RELOAD, 8'hf0, r);
        wr(`ASP_OFF_TMR, 8'h11, r);
        peer.bit_cyc = 32;
        for (int i = 0; i < 8; i++) begin
            if (i != 1) set_ctrl(cv[i]);
            lfsr = lfsr_next(lfsr);
            rx_one(lfsr[7:0], i[0]);
        end
        wrap_up();
    end

    // hang guard
    initial begin
        repeat (60000) @(posedge i_clk_sys);
        n_errors++;
        wrap_up();
    end
endmodule
